// ### pkg/slot_port_pkg.sv
`default_nettype none
package slot_port_pkg;
	// register byte offsets, one aligned 32-bit word each
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_TX_SLOT = 5'h08;
	localparam logic [4:0] OFS_RX_SLOT = 5'h0c;
	localparam logic [4:0] OFS_TX_IC = 5'h10;
	localparam logic [4:0] OFS_RX_IC = 5'h14;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h1c;
	// control bits
	localparam int CTRL_EN = 0;
	localparam int CTRL_REV = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// status bits
	localparam int STAT_MODE = 0;
	localparam int STAT_ADDR = 1;
	localparam int STAT_TWIN = 4;
	localparam int STAT_LOCK = 5;
	// interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_SLOT = 0;
	localparam int IRQ_IC = 1;
	localparam int IRQ_FRAME = 2;
	localparam int IRQ_LOST = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
	// frame timing in kHz; half-bits per frame follow from the two rates
	localparam int FRAME_KHZ = 8;
	localparam int TE_DCL_KHZ = 1536;
	localparam int NTE_DCL_KHZ = 4096;
	localparam logic [9:0] TE_HB = 10'(TE_DCL_KHZ / FRAME_KHZ);
	localparam logic [9:0] NTE_HB = 10'(NTE_DCL_KHZ / FRAME_KHZ);
	localparam logic [9:0] HB_INIT = 10'h3ff;
	// slot layout in bit positions
	localparam int WORD_BITS = 16;
	localparam logic [8:0] IC_BASE = 9'h020;
	localparam logic [8:0] TWIN_OFS = 9'h010;
	// system clock and sync-loss watchdog
	localparam int MCLK_KHZ = 200000;
	localparam int FRAME_CYC = MCLK_KHZ / FRAME_KHZ;
	localparam int LOSS_FRAMES = 2;
	localparam logic [15:0] WORD_RST = 16'h0000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HUNT = 2'b01,
		ST_RUN = 2'b11
	} link_state_t;
endpackage
`default_nettype wire

// ### rtl/slot_port.sv
// Functional notes
// - shift bits on bit clock, down and up
// - data-down line released unless transmitting
// - data-up line released outside own slot and, without reversal, the terminal control channel
// - terminal reversal sends control channel downstream
// - terminal reversal receives control channel upstream
// - mode strap zero terminal, one line card
// - three address straps pick one slot
// - line card twin pick splits shared slot
// - reset clears every internal register but the half-bit counter, data-line drive values and waitrequest, which load ones
// - interrupt pin pulls low, else released
// - all timing taken from upstream party
// - frame rate 8 kHz in both modes
`timescale 1ns/100ps
`default_nettype none
module slot_port #(
	parameter int SYNC_LOSS_CYC = slot_port_pkg::LOSS_FRAMES *
		slot_port_pkg::FRAME_CYC // watchdog span in system clocks
) (
	input wire logic MCLK_I, // 200 MHz system clock
	input wire logic RESETN_I, // synchronous reset, active low
	input wire logic CE_I, // clock enable, freezes all state when low
	input wire logic [4:0] AVS_ADDRESS_I, // byte address
	input wire logic AVS_READ_I, // read request
	input wire logic AVS_WRITE_I, // write request
	input wire logic [31:0] AVS_WRITEDATA_I, // write data
	output logic [31:0] AVS_READDATA_O, // read data
	output logic AVS_WAITREQUEST_O, // high while request not yet served
	input wire logic FSC_I, // frame sync pin
	input wire logic DCL_I, // bit clock pin
	input wire logic DD_I, // data-down pin level
	output logic DD_O, // data-down drive value
	output logic DD_OE_O, // data-down drive enable
	input wire logic DU_I, // data-up pin level
	output logic DU_O, // data-up drive value
	output logic DU_OE_O, // data-up drive enable
	input wire logic BUS_MODE_STRAP_I, // 0 terminal, 1 line card
	input wire logic SLOT_ADDR_BIT0_I, // slot address bit 0
	input wire logic SLOT_ADDR_BIT1_I, // slot address bit 1
	input wire logic SLOT_ADDR_BIT2_I, // slot address bit 2
	input wire logic TWIN_DEVICE_PICK_I, // 0 first, 1 second device
	input wire logic INTERRUPT_OUT_LOW_I, // interrupt wire level, unused
	output logic INTERRUPT_OUT_LOW_O, // interrupt drive value, always 0
	output logic INTERRUPT_OUT_LOW_OE_O // interrupt drive enable
);
	localparam int NSYNC = 9; // pins passing the synchroniser
	logic [NSYNC-1:0] pin_raw; // raw pin vector
	logic [NSYNC-1:0] meta_r; // first stage, read only by second
	logic [NSYNC-1:0] sync_r; // second stage, safe to use
	logic dcl_q_r; // previous synced bit clock
	logic fsc_q_r; // previous synced frame sync
	logic dcl_rise, dcl_fall, fsc_rise; // edge events
	logic dcl_s, fsc_s, dd_s, du_s, nte, twin; // synced pins
	logic [2:0] addr; // synced slot address
	slot_port_pkg::link_state_t state_r, state_nxt; // link state
	logic [1:0] ctrl_r; // enable and reversal
	logic [15:0] tx_slot_r, tx_ic_r; // words to send
	logic [15:0] rx_slot_r, rx_ic_r; // words received
	logic [15:0] rx_slot_sh_r, rx_ic_sh_r; // receive shifters
	logic [slot_port_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r; // sticky, mask
	logic [slot_port_pkg::IRQ_W-1:0] irq_set; // events this cycle
	logic [9:0] hb_cnt_r, hb_nxt; // half-bit counter and its next value
	logic [9:0] hb_len; // half-bits per frame for the mode
	logic [15:0] to_cnt_r; // watchdog since last frame sync
	logic [8:0] slot_base; // own slot first bit
	logic [4:0] own_hit_n, ic_hit_n; // hit and offset at drive point
	logic [4:0] own_hit_s, ic_hit_s; // hit and offset at sample point
	logic te_rev; // terminal mode with reversal
	logic run, in_frame_n, in_frame_s; // qualifiers
	logic samp, ic_samp, ic_src; // sample strobes and source
	logic own_samp; // own-slot sample, yields to the control channel
	logic word_end; // closing fall of the last bit of a word
	logic bus_req, bus_go; // bus request, bus action edge
	logic timeout; // watchdog expired

	// hit test: in-window flag on top, bit offset below
	function automatic logic [4:0] slot_hit(input logic [8:0] idx,
		input logic [8:0] base);
		logic [8:0] diff;
		diff = idx - base;
		slot_hit = {diff < 9'(slot_port_pkg::WORD_BITS), diff[3:0]};
	endfunction

	assign pin_raw = {TWIN_DEVICE_PICK_I, SLOT_ADDR_BIT2_I, SLOT_ADDR_BIT1_I,
		SLOT_ADDR_BIT0_I, BUS_MODE_STRAP_I, DU_I, DD_I, FSC_I, DCL_I};

	// two flops per pin; the bit clock is sampled like any other pin
	generate
		for (genvar g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge MCLK_I) begin
				if (!RESETN_I) begin
					meta_r[g] <= 1'b0;
					sync_r[g] <= 1'b0;
				end else if (CE_I) begin
					meta_r[g] <= pin_raw[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	assign {twin, addr, nte, du_s, dd_s, fsc_s, dcl_s} = sync_r;

	// edge history of the synced clocks
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			dcl_q_r <= 1'b0;
			fsc_q_r <= 1'b0;
		end else if (CE_I) begin
			dcl_q_r <= dcl_s;
			fsc_q_r <= fsc_s;
		end
	end

	// a stopped low bit clock simply yields no edges
	assign dcl_rise = dcl_s & ~dcl_q_r;
	assign dcl_fall = ~dcl_s & dcl_q_r;
	assign fsc_rise = fsc_s & ~fsc_q_r;
	assign run = (state_r == slot_port_pkg::ST_RUN);
	assign hb_len = nte ? slot_port_pkg::NTE_HB : slot_port_pkg::TE_HB;
	assign te_rev = ~nte & ctrl_r[slot_port_pkg::CTRL_REV];
	// own slot: channel by address, upper half for the second twin in line card mode
	assign slot_base = {1'b0, addr, 5'h00} +
		((nte & twin) ? slot_port_pkg::TWIN_OFS : 9'h000);
	// coincident sync and clock edge: that edge is already bit 0
	assign hb_nxt = fsc_rise ? 10'h000 : hb_cnt_r + 10'h001;
	assign in_frame_n = hb_nxt < hb_len;
	assign in_frame_s = hb_cnt_r < hb_len;
	assign own_hit_n = slot_hit(hb_nxt[9:1], slot_base);
	assign ic_hit_n = slot_hit(hb_nxt[9:1], slot_port_pkg::IC_BASE);
	assign own_hit_s = slot_hit(hb_cnt_r[9:1], slot_base);
	assign ic_hit_s = slot_hit(hb_cnt_r[9:1], slot_port_pkg::IC_BASE);
	// sample on the falling edge closing the second half of a bit
	assign samp = run & dcl_fall & hb_cnt_r[0] & in_frame_s;
	assign ic_samp = samp & ~nte & ic_hit_s[4];
	// in terminal mode the control channel owns a colliding slot
	assign own_samp = samp & own_hit_s[4] & ~(~nte & ic_hit_s[4]);
	// words are 16-bit aligned, so offset 15 ends every one of them
	assign word_end = dcl_fall & hb_cnt_r[0] & (hb_cnt_r[4:1] == 4'hf);
	assign ic_src = te_rev ? du_s : dd_s;
	assign timeout = to_cnt_r == 16'(SYNC_LOSS_CYC - 1);

	// half-bit counter, restarted by each frame sync edge
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			hb_cnt_r <= slot_port_pkg::HB_INIT;
		end else if (CE_I) begin
			if (dcl_rise) begin
				hb_cnt_r <= hb_nxt;
			end else if (fsc_rise) begin
				hb_cnt_r <= slot_port_pkg::HB_INIT;
			end
		end
	end

	// watchdog: two frames without sync means the upstream has gone
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			to_cnt_r <= 16'h0000;
		end else if (CE_I) begin
			if (fsc_rise || !run || timeout) begin
				to_cnt_r <= 16'h0000;
			end else begin
				to_cnt_r <= to_cnt_r + 16'h0001;
			end
		end
	end

	// link state: drive only once frame sync has been seen
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			slot_port_pkg::ST_IDLE: begin
				if (ctrl_r[slot_port_pkg::CTRL_EN]) begin
					state_nxt = slot_port_pkg::ST_HUNT;
				end
			end
			slot_port_pkg::ST_HUNT: begin
				if (!ctrl_r[slot_port_pkg::CTRL_EN]) begin
					state_nxt = slot_port_pkg::ST_IDLE;
				end else if (fsc_rise) begin
					state_nxt = slot_port_pkg::ST_RUN;
				end
			end
			slot_port_pkg::ST_RUN: begin
				if (!ctrl_r[slot_port_pkg::CTRL_EN]) begin
					state_nxt = slot_port_pkg::ST_IDLE;
				end else if (timeout && !fsc_rise) begin
					state_nxt = slot_port_pkg::ST_HUNT;
				end
			end
			default: begin
				state_nxt = slot_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			state_r <= slot_port_pkg::ST_IDLE;
		end else if (CE_I) begin
			state_r <= state_nxt;
		end
	end

	// drive values change only on rising bit clock; enables also drop at word end and when not running
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			DU_O <= 1'b1;
			DU_OE_O <= 1'b0;
			DD_O <= 1'b1;
			DD_OE_O <= 1'b0;
		end else if (CE_I) begin
			if (!run) begin
				DU_OE_O <= 1'b0;
				DD_OE_O <= 1'b0;
			end else if (dcl_rise) begin
				// control channel has priority over a colliding own slot
				if (!nte && ic_hit_n[4] && in_frame_n) begin
					DU_OE_O <= ~te_rev;
					DD_OE_O <= te_rev;
					DU_O <= tx_ic_r[4'hf - ic_hit_n[3:0]];
					DD_O <= tx_ic_r[4'hf - ic_hit_n[3:0]];
				end else if (own_hit_n[4] && in_frame_n) begin
					DU_OE_O <= 1'b1;
					DD_OE_O <= 1'b0;
					DU_O <= tx_slot_r[4'hf - own_hit_n[3:0]];
				end else begin
					DU_OE_O <= 1'b0;
					DD_OE_O <= 1'b0;
				end
			end else if (word_end) begin
				// let go now: the bit clock may stop and never rise again
				DU_OE_O <= 1'b0;
				DD_OE_O <= 1'b0;
			end
		end
	end

	// receive shifters, msb first; commit on the last bit of a word
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			rx_slot_sh_r <= slot_port_pkg::WORD_RST;
			rx_ic_sh_r <= slot_port_pkg::WORD_RST;
			rx_slot_r <= slot_port_pkg::WORD_RST;
			rx_ic_r <= slot_port_pkg::WORD_RST;
		end else if (CE_I) begin
			if (own_samp) begin
				rx_slot_sh_r <= {rx_slot_sh_r[14:0], dd_s};
				if (own_hit_s[3:0] == 4'hf) begin
					rx_slot_r <= {rx_slot_sh_r[14:0], dd_s};
				end
			end
			if (ic_samp) begin
				rx_ic_sh_r <= {rx_ic_sh_r[14:0], ic_src};
				if (ic_hit_s[3:0] == 4'hf) begin
					rx_ic_r <= {rx_ic_sh_r[14:0], ic_src};
				end
			end
		end
	end

	assign irq_set = {run & timeout & ~fsc_rise, run & fsc_rise,
		ic_samp & (ic_hit_s[3:0] == 4'hf),
		own_samp & (own_hit_s[3:0] == 4'hf)};
	assign bus_req = AVS_READ_I | AVS_WRITE_I;
	assign bus_go = bus_req & ~AVS_WAITREQUEST_O;

	// one wait state, then the request is served at the next edge
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			AVS_WAITREQUEST_O <= 1'b1;
		end else if (CE_I) begin
			AVS_WAITREQUEST_O <= ~(bus_req & AVS_WAITREQUEST_O);
		end
	end

	// read data registered in the wait cycle; unmapped reads give zero
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			AVS_READDATA_O <= 32'h00000000;
		end else if (CE_I && AVS_READ_I && AVS_WAITREQUEST_O) begin
			case ({AVS_ADDRESS_I[4:2], 2'b00})
				slot_port_pkg::OFS_CTRL: AVS_READDATA_O <= {30'h0, ctrl_r};
				slot_port_pkg::OFS_STATUS: begin
					AVS_READDATA_O <= {26'h0, run, twin, addr, nte};
				end
				slot_port_pkg::OFS_TX_SLOT: AVS_READDATA_O <= {16'h0, tx_slot_r};
				slot_port_pkg::OFS_RX_SLOT: AVS_READDATA_O <= {16'h0, rx_slot_r};
				slot_port_pkg::OFS_TX_IC: AVS_READDATA_O <= {16'h0, tx_ic_r};
				slot_port_pkg::OFS_RX_IC: AVS_READDATA_O <= {16'h0, rx_ic_r};
				slot_port_pkg::OFS_IRQ_STAT: AVS_READDATA_O <= {28'h0, irq_stat_r};
				slot_port_pkg::OFS_IRQ_MASK: AVS_READDATA_O <= {28'h0, irq_mask_r};
				default: AVS_READDATA_O <= 32'h00000000;
			endcase
		end
	end

	// software registers, written at the edge that ends the wait
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			ctrl_r <= slot_port_pkg::CTRL_RST;
			tx_slot_r <= slot_port_pkg::WORD_RST;
			tx_ic_r <= slot_port_pkg::WORD_RST;
			irq_mask_r <= slot_port_pkg::IRQ_RST;
		end else if (CE_I && bus_go && AVS_WRITE_I) begin
			case ({AVS_ADDRESS_I[4:2], 2'b00})
				slot_port_pkg::OFS_CTRL: ctrl_r <= AVS_WRITEDATA_I[1:0];
				slot_port_pkg::OFS_TX_SLOT: tx_slot_r <= AVS_WRITEDATA_I[15:0];
				slot_port_pkg::OFS_TX_IC: tx_ic_r <= AVS_WRITEDATA_I[15:0];
				slot_port_pkg::OFS_IRQ_MASK: begin
					irq_mask_r <= AVS_WRITEDATA_I[slot_port_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			irq_stat_r <= slot_port_pkg::IRQ_RST;
		end else if (CE_I) begin
			if (bus_go && AVS_WRITE_I &&
				{AVS_ADDRESS_I[4:2], 2'b00} == slot_port_pkg::OFS_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r &
					~AVS_WRITEDATA_I[slot_port_pkg::IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_r <= irq_stat_r | irq_set;
			end
		end
	end

	// open-drain request: pull low while any unmasked bit is set
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			INTERRUPT_OUT_LOW_O <= 1'b0;
			INTERRUPT_OUT_LOW_OE_O <= 1'b0;
		end else if (CE_I) begin
			INTERRUPT_OUT_LOW_O <= 1'b0;
			INTERRUPT_OUT_LOW_OE_O <= |(irq_stat_r & irq_mask_r);
		end
	end

	// checks on the driven side
	AST_DD_QUIET: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I) (CE_I && !run) |=> !DD_OE_O)
		else $error("data-down driven while idle");
	AST_DU_QUIET: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I) (CE_I && !run) |=> !DU_OE_O)
		else $error("data-up driven while idle");
	AST_DD_REV: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I) $rose(DD_OE_O) |-> $past(te_rev && ic_hit_n[4]))
		else $error("data-down driven without reversal");
	AST_IC_SRC: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I)
		(ic_samp && CE_I) |=> rx_ic_sh_r[0] == $past(te_rev ? du_s : dd_s))
		else $error("control channel taken from wrong line");
	AST_MODE_LEN: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I)
		(CE_I && !nte && hb_cnt_r >= slot_port_pkg::TE_HB &&
		hb_cnt_r != slot_port_pkg::HB_INIT) |-> !DU_OE_O && !DD_OE_O)
		else $error("driving past the terminal frame end");
	AST_OWN_SLOT: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I) $rose(DU_OE_O) |->
		$past(dcl_rise) && $past(own_hit_n[4] || ic_hit_n[4]))
		else $error("data-up driven outside own slot");
	AST_TWIN: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I)
		$rose(DU_OE_O) |-> hb_cnt_r[5:1] == ((nte && twin) ? 5'h10 : 5'h00))
		else $error("slot start ignores twin pick");
	AST_RESET: assert property (@(posedge MCLK_I)
		!RESETN_I |=> irq_stat_r == slot_port_pkg::IRQ_RST && ctrl_r ==
		slot_port_pkg::CTRL_RST && !DU_OE_O && !DD_OE_O && AVS_WAITREQUEST_O)
		else $error("reset left state behind");
	AST_IRQ_PIN: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I || !CE_I)
		(|(irq_stat_r & irq_mask_r)) |=> INTERRUPT_OUT_LOW_OE_O &&
		!INTERRUPT_OUT_LOW_O) else $error("interrupt not pulled low");
	AST_FSC_RESTART: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I)
		(CE_I && fsc_rise && !dcl_rise) |=> hb_cnt_r == slot_port_pkg::HB_INIT)
		else $error("counter not restarted on frame sync");
	AST_SHIFT_EDGE: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I) $changed(DU_O) |-> $past(dcl_rise))
		else $error("bit changed off clock");
	AST_SYNC_LOSS: assert property (@(posedge MCLK_I)
		disable iff (!RESETN_I)
		(CE_I && run && timeout && !fsc_rise && ctrl_r[slot_port_pkg::CTRL_EN])
		|=> state_r == slot_port_pkg::ST_HUNT &&
		irq_stat_r[slot_port_pkg::IRQ_LOST]) else $error("sync loss missed");
	AST_ONE_WAIT: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		(CE_I && bus_req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
		else $error("bus answer late");
	COV_SLOT_WORD: cover property (@(posedge MCLK_I)
		irq_set[slot_port_pkg::IRQ_SLOT]);
	COV_REV_DRIVE: cover property (@(posedge MCLK_I) $rose(DD_OE_O));
	COV_IRQ: cover property (@(posedge MCLK_I) $rose(INTERRUPT_OUT_LOW_OE_O));
endmodule
`default_nettype wire

// ### tb/iom_upstream.sv
`timescale 1ns/100ps
`default_nettype none
// upstream controller model: owns frame sync and the bit clock, drives
// its share of both data lines from per-bit masks and records each bit
module iom_upstream (
	output logic FSC_O, // frame sync
	output logic DCL_O, // bit clock, two periods per bit
	output logic DD_O, // data-down drive value
	output logic DD_OE_O, // data-down drive enable
	output logic DU_O, // data-up drive value
	output logic DU_OE_O, // data-up drive enable
	input wire logic DD_I, // resolved data-down level
	input wire logic DU_I, // resolved data-up level
	input wire logic DD_DEV_OE_I, // device enable on data-down
	input wire logic DU_DEV_OE_I // device enable on data-up
);
	logic [255:0] dd_seen; // data-down level per bit
	logic [255:0] du_seen; // data-up level per bit
	logic [255:0] dd_oe_seen; // device driving data-down per bit
	logic [255:0] du_oe_seen; // device driving data-up per bit

	// idle bus: clock stopped low, both lines left to their pull-ups
	initial begin
		FSC_O = 1'b0;
		DCL_O = 1'b0;
		DD_O = 1'b0;
		DD_OE_O = 1'b0;
		DU_O = 1'b0;
		DU_OE_O = 1'b0;
	end

	// one frame; the odd offset keeps the link out of phase with the core
	task automatic run_frame(input int nbits, input logic [255:0] dd_pat,
		input logic [255:0] dd_en, input logic [255:0] du_pat,
		input logic [255:0] du_en);
		int b;
		dd_seen = '0;
		du_seen = '0;
		dd_oe_seen = '0;
		du_oe_seen = '0;
		#13.7;
		FSC_O = 1'b1; // frame start edge
		#8; // sync leads the first clock rise by more than a core cycle
		for (int h = 0; h < 2 * nbits; h++) begin
			b = h / 2;
			// a new bit is launched on every even rise
			if (h % 2 == 0) begin
				DD_OE_O = dd_en[b];
				DD_O = dd_pat[b];
				DU_OE_O = du_en[b];
				DU_O = du_pat[b];
			end
			DCL_O = 1'b1; // 64 ns period, both modes
			#32;
			FSC_O = FSC_O && (h < 3);
			DCL_O = 1'b0;
			// sample on the fall that ends each bit
			if (h % 2 == 1) begin
				dd_seen[b] = DD_I;
				du_seen[b] = DU_I;
				dd_oe_seen[b] = DD_DEV_OE_I;
				du_oe_seen[b] = DU_DEV_OE_I;
			end
			#32;
		end
		DD_OE_O = 1'b0;
		DU_OE_O = 1'b0; // clock now rests low
	endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic m; // mode strap
		logic [2:0] a; // slot address
		logic t; // twin pick
		logic r; // reversal
		logic [15:0] tx; // word sent by the device
		logic [15:0] rx; // word sent by upstream
	} row_t;
	logic clk, rst_n, rd, wr, waitreq, mode, twin; // bus and straps
	logic [2:0] sa; // slot address straps
	logic [4:0] addr; // bus address
	logic [31:0] wdata, rdata, q; // bus data
	logic fsc, dcl, p_dd, p_dd_oe, p_du, p_du_oe; // upstream side
	logic dd_o, dd_oe, du_o, du_oe, irq_o, irq_oe; // device side
	logic dd_line, du_line, irq_line; // resolved wires
	int mismatches, tests_run, nb, own;
	logic own_hit, ic; // what the frame should carry
	row_t rows [7];
	logic [255:0] pdd, pddm, pdu, pdum, edd, eddm, edu, edum, xdd, xdu;

	// pull-ups on every shared line; any low driver wins
	assign dd_line = (dd_oe ? dd_o : 1'b1) & (p_dd_oe ? p_dd : 1'b1);
	assign du_line = (du_oe ? du_o : 1'b1) & (p_du_oe ? p_du : 1'b1);
	assign irq_line = irq_oe ? irq_o : 1'b1;

	slot_port #(.SYNC_LOSS_CYC(8000)) i_slot_port (.MCLK_I(clk),
		.RESETN_I(rst_n), .CE_I(1'b1), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
		.FSC_I(fsc), .DCL_I(dcl), .DD_I(dd_line), .DD_O(dd_o),
		.DD_OE_O(dd_oe), .DU_I(du_line), .DU_O(du_o), .DU_OE_O(du_oe),
		.BUS_MODE_STRAP_I(mode), .SLOT_ADDR_BIT0_I(sa[0]),
		.SLOT_ADDR_BIT1_I(sa[1]), .SLOT_ADDR_BIT2_I(sa[2]),
		.TWIN_DEVICE_PICK_I(twin), .INTERRUPT_OUT_LOW_I(irq_line),
		.INTERRUPT_OUT_LOW_O(irq_o), .INTERRUPT_OUT_LOW_OE_O(irq_oe));

	iom_upstream i_iom_upstream (.FSC_O(fsc), .DCL_O(dcl), .DD_O(p_dd),
		.DD_OE_O(p_dd_oe), .DU_O(p_du), .DU_OE_O(p_du_oe), .DD_I(dd_line),
		.DU_I(du_line), .DD_DEV_OE_I(dd_oe), .DU_DEV_OE_I(du_oe));

	// 200 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// verdict and end of run
	task summarize;
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// register value compare
	task chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// per-bit line record compare
	task chk_line(input string n, input logic [255:0] e,
		input logic [255:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// one bus transfer; waitrequest is looked at on rising edges only
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (n >= 20) begin
			mismatches++;
			summarize();
		end
		q = rdata; // value standing at the edge that ends the wait
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// lay a word msb first into a bit record and mark it driven
	task put(inout logic [255:0] v, inout logic [255:0] m, input int p,
		input logic [15:0] w);
		for (int i = 0; i < 16; i++) begin
			v[p + i] = w[15 - i];
			m[p + i] = 1'b1;
		end
	endtask

	// one upstream frame, then back onto the core clock
	task frame;
		i_iom_upstream.run_frame(nb, pdd, pddm, pdu, pdum);
		@(posedge clk);
	endtask

	// main sequence
	initial begin
		{rst_n, rd, wr, addr, wdata, mode, twin, sa} = '0;
		{pdd, pddm, pdu, pdum} = '0;
		mismatches = 0;
		tests_run = 0;
		rows[0] = {1'b1, 3'h0, 1'b0, 1'b0, 16'ha5c3, 16'h3c5a};
		rows[1] = {1'b1, 3'h7, 1'b1, 1'b0, 16'h8001, 16'h7ffe};
		rows[2] = {1'b1, 3'h3, 1'b0, 1'b0, 16'h1234, 16'hedcb};
		rows[3] = {1'b0, 3'h0, 1'b0, 1'b0, 16'hc0de, 16'h0bad};
		rows[4] = {1'b0, 3'h2, 1'b1, 1'b1, 16'h5a5a, 16'h96e1};
		rows[5] = {1'b0, 3'h1, 1'b0, 1'b0, 16'h4321, 16'h8765};
		rows[6] = {1'b0, 3'h3, 1'b0, 1'b1, 16'h0ff0, 16'hf00f};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		mode <= 1'b1;
		repeat (4) @(posedge clk);
		// bus left disabled: the device must stay off both lines
		nb = 256;
		frame();
		chk_line("dd_oe", '0, i_iom_upstream.dd_oe_seen);
		chk_line("du_oe", '0, i_iom_upstream.du_oe_seen);
		bus(1'b1, slot_port_pkg::OFS_IRQ_MASK, 32'h1);
		// table of slot placements across modes, addresses and twins
		foreach (rows[k]) begin
			bus(1'b1, slot_port_pkg::OFS_CTRL, 32'h0);
			mode <= rows[k].m;
			sa <= rows[k].a;
			twin <= rows[k].t;
			nb = rows[k].m ? 256 : 96;
			own = rows[k].a * 32 + ((rows[k].m && rows[k].t) ? 16 : 0);
			own_hit = rows[k].m || (rows[k].a != 1 && rows[k].a < 3);
			ic = !rows[k].m;
			{pdd, pddm, pdu, pdum, edd, eddm, edu, edum} = '0;
			if (own_hit)
				put(pdd, pddm, own, rows[k].rx);
			if (own_hit)
				put(edu, edum, own, rows[k].tx);
			if (ic && rows[k].r)
				put(pdu, pdum, 32, ~rows[k].rx);
			if (ic && rows[k].r)
				put(edd, eddm, 32, ~rows[k].tx);
			if (ic && !rows[k].r)
				put(pdd, pddm, 32, ~rows[k].rx);
			if (ic && !rows[k].r)
				put(edu, edum, 32, ~rows[k].tx);
			for (int b = 0; b < 256; b++) begin
				xdd[b] = (b < nb) && (eddm[b] ? edd[b] : (!pddm[b] | pdd[b]));
				xdu[b] = (b < nb) && (edum[b] ? edu[b] : (!pdum[b] | pdu[b]));
			end
			bus(1'b1, slot_port_pkg::OFS_TX_SLOT, {16'h0, rows[k].tx});
			bus(1'b1, slot_port_pkg::OFS_TX_IC, {16'h0, ~rows[k].tx});
			bus(1'b1, slot_port_pkg::OFS_CTRL, {30'h0, rows[k].r, 1'b1});
			frame();
			bus(1'b1, slot_port_pkg::OFS_IRQ_STAT, 32'hf);
			frame();
			chk_line("du_oe", edum, i_iom_upstream.du_oe_seen);
			chk_line("dd_oe", eddm, i_iom_upstream.dd_oe_seen);
			chk_line("du", xdu, i_iom_upstream.du_seen);
			chk_line("dd", xdd, i_iom_upstream.dd_seen);
			bus(1'b0, slot_port_pkg::OFS_STATUS, 32'h0);
			chk_reg("status", {26'h0, 1'b1, rows[k].t, rows[k].a,
				rows[k].m}, q);
			bus(1'b0, slot_port_pkg::OFS_RX_SLOT, 32'h0);
			if (own_hit)
				chk_reg("rx_slot", {16'h0, rows[k].rx}, q);
			bus(1'b0, slot_port_pkg::OFS_RX_IC, 32'h0);
			if (ic)
				chk_reg("rx_ic", {16'h0, ~rows[k].rx}, q);
			bus(1'b0, slot_port_pkg::OFS_IRQ_STAT, 32'h0);
			chk_reg("irq_stat", {28'h0, 2'b01, ic, own_hit}, q);
			chk_reg("irq_pin", {31'h0, !own_hit}, {31'h0, irq_line});
			bus(1'b1, slot_port_pkg::OFS_IRQ_STAT, 32'hf);
			repeat (3) @(posedge clk);
			chk_reg("irq_pin", 32'h1, {31'h0, irq_line});
		end
		// frame sync stops: link must drop out and flag the loss
		bus(1'b1, slot_port_pkg::OFS_IRQ_MASK, 32'h8);
		repeat (8500) @(posedge clk);
		bus(1'b0, slot_port_pkg::OFS_IRQ_STAT, 32'h0);
		chk_reg("irq_stat", 32'h8, q);
		bus(1'b0, slot_port_pkg::OFS_STATUS, 32'h0);
		chk_reg("status", 32'h6, q);
		chk_reg("irq_pin", 32'h0, {31'h0, irq_line});
		chk_reg("line_oe", 32'h0, {30'h0, dd_oe, du_oe});
		// reset in mid-run clears what software wrote
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk_reg("irq_pin", 32'h1, {31'h0, irq_line});
		bus(1'b0, slot_port_pkg::OFS_CTRL, 32'h0);
		chk_reg("ctrl", 32'h0, q);
		bus(1'b0, slot_port_pkg::OFS_TX_SLOT, 32'h0);
		chk_reg("tx_slot", 32'h0, q);
		bus(1'b0, slot_port_pkg::OFS_IRQ_MASK, 32'h0);
		chk_reg("irq_mask", 32'h0, q);
		bus(1'b0, slot_port_pkg::OFS_RX_IC, 32'h0);
		chk_reg("rx_ic", 32'h0, q);
		summarize();
	end

	// guard against a hang anywhere in the run
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
